/* File: logic/l4_match_pkg.sv */
// constants and types for the layer-4 field matcher
package l4_match_pkg;
   // register offsets, byte addresses on the register bus
   localparam int unsigned AXI_AW        = 8;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_ICMP      = 8'h04;
   localparam logic [7:0]  OFS_SRC_SEL   = 8'h08;
   localparam logic [7:0]  OFS_SRC_PORT  = 8'h0c;
   localparam logic [7:0]  OFS_DST_SEL   = 8'h10;
   localparam logic [7:0]  OFS_DST_PORT  = 8'h14;
   localparam logic [7:0]  OFS_TCP_FLAGS = 8'h18;
   localparam logic [7:0]  OFS_STATUS    = 8'h1c;
   localparam logic [7:0]  OFS_FRAME_CNT = 8'h20;
   localparam logic [7:0]  OFS_MATCH_CNT = 8'h24;

   // field positions
   localparam int unsigned CTRL_EN_BIT      = 0;
   localparam int unsigned CTRL_PROTO_LSB   = 1;
   localparam int unsigned ICMP_TSEL_BIT    = 0;
   localparam int unsigned ICMP_CSEL_BIT    = 1;
   localparam int unsigned ICMP_TYPE_LSB    = 8;
   localparam int unsigned ICMP_CODE_LSB    = 16;
   localparam int unsigned PORT_HIGH_LSB    = 16;
   localparam int unsigned STAT_MATCH_BIT   = 0;
   localparam int unsigned STAT_PROTO_BIT   = 1;
   localparam int unsigned TCP_FLAG_COUNT   = 6;

   // reset values
   localparam logic        RST_ENTRY_EN  = 1'b0;
   localparam logic [7:0]  RST_ICMP_VAL  = 8'h00;
   localparam logic [15:0] RST_PORT_LOW  = 16'h0000;
   localparam logic [15:0] RST_PORT_HIGH = 16'hffff;
   localparam logic [11:0] RST_TCP_CFG   = 12'h0aaa;
   localparam logic [31:0] RST_COUNT     = 32'h0000_0000;

   // protocol selection of the entry
   localparam logic [1:0] PROTO_ANY  = 2'h0;
   localparam logic [1:0] PROTO_ICMP = 2'h1;
   localparam logic [1:0] PROTO_UDP  = 2'h2;
   localparam logic [1:0] PROTO_TCP  = 2'h3;

   // ip protocol numbers carried by frames
   localparam logic [7:0] IPP_ICMP4 = 8'h01;
   localparam logic [7:0] IPP_TCP   = 8'h06;
   localparam logic [7:0] IPP_UDP   = 8'h11;
   localparam logic [7:0] IPP_ICMP6 = 8'h3a;

   // port selector and tcp flag settings
   localparam logic [1:0] PSEL_ANY      = 2'h0;
   localparam logic [1:0] PSEL_SPECIFIC = 2'h1;
   localparam logic [1:0] PSEL_RANGE    = 2'h2;
   localparam logic [1:0] FLAG_CLEAR    = 2'h0;
   localparam logic [1:0] FLAG_SET      = 2'h1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP    = 2'b10
   } wr_state_e;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_e;
endpackage : l4_match_pkg

/* File: logic/l4_port_if.sv */
`timescale 1ns/10ps
// bundle between the matcher and one port checker
interface l4_port_if;
   logic [1:0]  sel;
   logic [15:0] low;
   logic [15:0] high;
   logic [15:0] port;
   logic        hit;
   modport chk (input sel, input low, input high, input port, output hit);
   modport owner (output sel, output low, output high, output port,
                  input hit);
endinterface : l4_port_if

/* File: logic/l4_port_check.sv */
`timescale 1ns/10ps
// port check against any, one value or an inclusive range
module l4_port_check (
   l4_port_if.chk pif
);
   always_comb begin
      case (pif.sel)
         l4_match_pkg::PSEL_SPECIFIC: begin
            pif.hit = (pif.port == pif.low);
         end
         l4_match_pkg::PSEL_RANGE: begin
            pif.hit = (pif.port >= pif.low) &&
                      (pif.port <= pif.high);
         end
         default: begin
            pif.hit = 1'b1;
         end
      endcase
   end
endmodule : l4_port_check

/* File: logic/acl_l4_field_matcher.sv */
`timescale 1ns/10ps
// layer-4 field matcher of one access_list_entry, axi4-lite registers
//
// How it works
// - icmp type any ignores frame type
// - icmp type specific needs equal 8-bit value
// - icmp code any ignores frame code
// - icmp code specific needs equal value
// - source port any ignores source port
// - source port specific needs equal value
// - source port range needs port within bounds
// - destination port any ignores destination port
// - destination port specific needs equal value
// - destination port range needs port within bounds
// - fin flag: clear, set or any
// - syn flag: clear, set or any
// - rst flag: clear, set or any
// - psh flag: clear, set or any
// - ack flag: clear, set or any
// - urg flag: clear, set or any
// - l4 checks only for selected protocol frames
module acl_l4_field_matcher (
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   // register bus
   input  wire logic [7:0]  i_axi_awaddr,
   input  wire logic [2:0]  i_axi_awprot,
   input  wire logic        i_axi_awvalid,
   output logic             o_axi_awready,
   input  wire logic [31:0] i_axi_wdata,
   input  wire logic [3:0]  i_axi_wstrb,
   input  wire logic        i_axi_wvalid,
   output logic             o_axi_wready,
   output logic [1:0]       o_axi_bresp,
   output logic             o_axi_bvalid,
   input  wire logic        i_axi_bready,
   input  wire logic [7:0]  i_axi_araddr,
   input  wire logic [2:0]  i_axi_arprot,
   input  wire logic        i_axi_arvalid,
   output logic             o_axi_arready,
   output logic [31:0]      o_axi_rdata,
   output logic [1:0]       o_axi_rresp,
   output logic             o_axi_rvalid,
   input  wire logic        i_axi_rready,
   // parsed frame headers from the receive pipeline
   input  wire logic        i_frm_valid,
   input  wire logic [7:0]  i_frm_ip_proto,
   input  wire logic [7:0]  i_frm_icmp_type,
   input  wire logic [7:0]  i_frm_icmp_code,
   input  wire logic [15:0] i_frm_src_port,
   input  wire logic [15:0] i_frm_dst_port,
   input  wire logic [5:0]  i_frm_tcp_flags,
   // match result
   output logic             o_match_valid,
   output logic             o_match
);

   // configuration fields
   logic        entry_en;
   logic [1:0]  proto_sel;
   logic        icmp_type_sel;
   logic        icmp_code_sel;
   logic [7:0]  icmp_type;
   logic [7:0]  icmp_code;
   logic [1:0]  src_sel;
   logic [15:0] src_low;
   logic [15:0] src_high;
   logic [1:0]  dst_sel;
   logic [15:0] dst_low;
   logic [15:0] dst_high;
   logic [11:0] tcp_cfg;
   // status
   logic [31:0] frame_count;
   logic [31:0] match_count;
   logic        last_match;
   logic        last_proto_hit;
   // bus channel state
   l4_match_pkg::wr_state_e wr_state;
   l4_match_pkg::rd_state_e rd_state;
   logic        aw_full;
   logic        w_full;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_fire;
   logic [31:0] wr_word;
   // match datapath
   logic        is_icmp;
   logic        is_udp;
   logic        is_tcp;
   logic        icmp_ok;
   logic        flags_ok;
   logic        proto_hit;
   logic        l4_hit;
   logic        next_match;
   l4_port_if src_if ();
   l4_port_if dst_if ();

   // word-aligned offset of a byte address
   function automatic logic [7:0] word_ofs(input logic [7:0] addr);
      return {addr[7:2], 2'b00};
   endfunction : word_ofs

   // mapped words run without a gap up to the match counter
   function automatic logic addr_known(input logic [7:0] addr);
      return word_ofs(addr) <= l4_match_pkg::OFS_MATCH_CNT;
   endfunction : addr_known

   // read-back word of a register, zero when unmapped
   function automatic logic [31:0] read_word(input logic [7:0] addr);
      logic [7:0] ofs;
      ofs = word_ofs(addr);
      if (ofs == l4_match_pkg::OFS_CTRL) begin
         return {29'h0000_0000, proto_sel, entry_en};
      end else if (ofs == l4_match_pkg::OFS_ICMP) begin
         return {8'h00, icmp_code, icmp_type, 6'h00,
                 icmp_code_sel, icmp_type_sel};
      end else if (ofs == l4_match_pkg::OFS_SRC_SEL) begin
         return {30'h0000_0000, src_sel};
      end else if (ofs == l4_match_pkg::OFS_SRC_PORT) begin
         return {src_high, src_low};
      end else if (ofs == l4_match_pkg::OFS_DST_SEL) begin
         return {30'h0000_0000, dst_sel};
      end else if (ofs == l4_match_pkg::OFS_DST_PORT) begin
         return {dst_high, dst_low};
      end else if (ofs == l4_match_pkg::OFS_TCP_FLAGS) begin
         return {20'h0_0000, tcp_cfg};
      end else if (ofs == l4_match_pkg::OFS_STATUS) begin
         return {30'h0000_0000, last_proto_hit, last_match};
      end else if (ofs == l4_match_pkg::OFS_FRAME_CNT) begin
         return frame_count;
      end else if (ofs == l4_match_pkg::OFS_MATCH_CNT) begin
         return match_count;
      end else begin
         return 32'h0000_0000;
      end
   endfunction : read_word

   // byte-lane merge under the write strobes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
      logic [31:0] mask;
      mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (new_val & mask) | (old_val & ~mask);
   endfunction : merge_bytes

   // three-way tcp flag setting
   function automatic logic flag_ok(input logic [1:0] setting,
                                    input logic       flag);
      case (setting)
         l4_match_pkg::FLAG_CLEAR: return !flag;
         l4_match_pkg::FLAG_SET:   return flag;
         default:                  return 1'b1;
      endcase
   endfunction : flag_ok

   // write channel
   assign o_axi_awready = (wr_state == l4_match_pkg::WR_COLLECT) && !aw_full;
   assign o_axi_wready  = (wr_state == l4_match_pkg::WR_COLLECT) && !w_full;
   assign o_axi_bvalid  = (wr_state == l4_match_pkg::WR_RESP);
   assign wr_fire = (wr_state == l4_match_pkg::WR_COLLECT) &&
                    aw_full && w_full;
   always_comb wr_word = merge_bytes(read_word(aw_addr), w_data, w_strb);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_state    <= l4_match_pkg::WR_COLLECT;
         aw_full     <= 1'b0;
         w_full      <= 1'b0;
         aw_addr     <= 8'h00;
         w_data      <= 32'h0000_0000;
         w_strb      <= 4'h0;
         o_axi_bresp <= l4_match_pkg::RESP_OKAY;
      end else begin
         case (wr_state)
            l4_match_pkg::WR_COLLECT: begin
               if (i_axi_awvalid && o_axi_awready) begin
                  aw_full <= 1'b1;
                  aw_addr <= i_axi_awaddr;
               end
               if (i_axi_wvalid && o_axi_wready) begin
                  w_full <= 1'b1;
                  w_data <= i_axi_wdata;
                  w_strb <= i_axi_wstrb;
               end
               if (wr_fire) begin
                  aw_full     <= 1'b0;
                  w_full      <= 1'b0;
                  o_axi_bresp <= addr_known(aw_addr) ?
                                 l4_match_pkg::RESP_OKAY :
                                 l4_match_pkg::RESP_SLVERR;
                  wr_state    <= l4_match_pkg::WR_RESP;
               end
            end
            l4_match_pkg::WR_RESP: begin
               if (i_axi_bready) begin
                  wr_state <= l4_match_pkg::WR_COLLECT;
               end
            end
            default: begin
               wr_state <= l4_match_pkg::WR_COLLECT;
            end
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         entry_en      <= l4_match_pkg::RST_ENTRY_EN;
         proto_sel     <= l4_match_pkg::PROTO_ANY;
         icmp_type_sel <= 1'b0;
         icmp_code_sel <= 1'b0;
         icmp_type     <= l4_match_pkg::RST_ICMP_VAL;
         icmp_code     <= l4_match_pkg::RST_ICMP_VAL;
         src_sel       <= l4_match_pkg::PSEL_ANY;
         src_low       <= l4_match_pkg::RST_PORT_LOW;
         src_high      <= l4_match_pkg::RST_PORT_HIGH;
         dst_sel       <= l4_match_pkg::PSEL_ANY;
         dst_low       <= l4_match_pkg::RST_PORT_LOW;
         dst_high      <= l4_match_pkg::RST_PORT_HIGH;
         tcp_cfg       <= l4_match_pkg::RST_TCP_CFG;
      end else if (wr_fire) begin
         if (word_ofs(aw_addr) == l4_match_pkg::OFS_CTRL) begin
            entry_en  <= wr_word[l4_match_pkg::CTRL_EN_BIT];
            proto_sel <= wr_word[l4_match_pkg::CTRL_PROTO_LSB +: 2];
         end else if (word_ofs(aw_addr) == l4_match_pkg::OFS_ICMP) begin
            icmp_type_sel <= wr_word[l4_match_pkg::ICMP_TSEL_BIT];
            icmp_code_sel <= wr_word[l4_match_pkg::ICMP_CSEL_BIT];
            icmp_type     <= wr_word[l4_match_pkg::ICMP_TYPE_LSB +: 8];
            icmp_code     <= wr_word[l4_match_pkg::ICMP_CODE_LSB +: 8];
         end else if (word_ofs(aw_addr) == l4_match_pkg::OFS_SRC_SEL) begin
            src_sel <= wr_word[1:0];
         end else if (word_ofs(aw_addr) == l4_match_pkg::OFS_SRC_PORT) begin
            src_low  <= wr_word[15:0];
            src_high <= wr_word[l4_match_pkg::PORT_HIGH_LSB +: 16];
         end else if (word_ofs(aw_addr) == l4_match_pkg::OFS_DST_SEL) begin
            dst_sel <= wr_word[1:0];
         end else if (word_ofs(aw_addr) == l4_match_pkg::OFS_DST_PORT) begin
            dst_low  <= wr_word[15:0];
            dst_high <= wr_word[l4_match_pkg::PORT_HIGH_LSB +: 16];
         end else if (word_ofs(aw_addr) == l4_match_pkg::OFS_TCP_FLAGS) begin
            tcp_cfg <= wr_word[11:0];
         end
      end
   end

   // read channel
   assign o_axi_arready = (rd_state == l4_match_pkg::RD_IDLE);
   assign o_axi_rvalid  = (rd_state == l4_match_pkg::RD_RESP);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_state    <= l4_match_pkg::RD_IDLE;
         o_axi_rdata <= 32'h0000_0000;
         o_axi_rresp <= l4_match_pkg::RESP_OKAY;
      end else begin
         case (rd_state)
            l4_match_pkg::RD_IDLE: begin
               if (i_axi_arvalid) begin
                  o_axi_rdata <= read_word(i_axi_araddr);
                  o_axi_rresp <= addr_known(i_axi_araddr) ?
                                 l4_match_pkg::RESP_OKAY :
                                 l4_match_pkg::RESP_SLVERR;
                  rd_state    <= l4_match_pkg::RD_RESP;
               end
            end
            l4_match_pkg::RD_RESP: begin
               if (i_axi_rready) begin
                  rd_state <= l4_match_pkg::RD_IDLE;
               end
            end
            default: begin
               rd_state <= l4_match_pkg::RD_IDLE;
            end
         endcase
      end
   end

   // port checkers
   assign src_if.sel  = src_sel;
   assign src_if.low  = src_low;
   assign src_if.high = src_high;
   assign src_if.port = i_frm_src_port;
   assign dst_if.sel  = dst_sel;
   assign dst_if.low  = dst_low;
   assign dst_if.high = dst_high;
   assign dst_if.port = i_frm_dst_port;

   l4_port_check u_src_check (.pif (src_if.chk));
   l4_port_check u_dst_check (.pif (dst_if.chk));

   // match decision
   always_comb begin
      is_icmp = (i_frm_ip_proto == l4_match_pkg::IPP_ICMP4) ||
                (i_frm_ip_proto == l4_match_pkg::IPP_ICMP6);
      is_udp  = (i_frm_ip_proto == l4_match_pkg::IPP_UDP);
      is_tcp  = (i_frm_ip_proto == l4_match_pkg::IPP_TCP);
      icmp_ok = (!icmp_type_sel ||
                 (i_frm_icmp_type == icmp_type)) &&
                (!icmp_code_sel ||
                 (i_frm_icmp_code == icmp_code));
      flags_ok = 1'b1;
      for (int f = 0; f < l4_match_pkg::TCP_FLAG_COUNT; f++) begin
         flags_ok = flags_ok && flag_ok(tcp_cfg[2*f +: 2],
                                        i_frm_tcp_flags[f]);
      end
      case (proto_sel)
         l4_match_pkg::PROTO_ICMP: begin
            proto_hit = is_icmp;
            l4_hit    = icmp_ok;
         end
         l4_match_pkg::PROTO_UDP: begin
            proto_hit = is_udp;
            l4_hit    = src_if.hit && dst_if.hit;
         end
         l4_match_pkg::PROTO_TCP: begin
            proto_hit = is_tcp;
            l4_hit    = src_if.hit && dst_if.hit && flags_ok;
         end
         default: begin
            proto_hit = 1'b1;
            l4_hit    = 1'b1;
         end
      endcase
      next_match = entry_en && proto_hit && l4_hit;
   end

   // registered result one cycle after the frame, kept as status
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_match_valid  <= 1'b0;
         o_match        <= 1'b0;
         last_match     <= 1'b0;
         last_proto_hit <= 1'b0;
      end else begin
         o_match_valid <= i_frm_valid;
         o_match       <= i_frm_valid && next_match;
         if (i_frm_valid) begin
            last_match     <= next_match;
            last_proto_hit <= proto_hit;
         end
      end
   end

   // counters, a write clears, a frame in the same cycle still counts
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         frame_count <= l4_match_pkg::RST_COUNT;
         match_count <= l4_match_pkg::RST_COUNT;
      end else begin
         if (wr_fire && word_ofs(aw_addr) == l4_match_pkg::OFS_FRAME_CNT) begin
            frame_count <= {31'h0000_0000, i_frm_valid};
         end else if (i_frm_valid) begin
            frame_count <= frame_count + 32'h0000_0001;
         end
         if (wr_fire && word_ofs(aw_addr) == l4_match_pkg::OFS_MATCH_CNT) begin
            match_count <= {31'h0000_0000, i_frm_valid && next_match};
         end else if (i_frm_valid && next_match) begin
            match_count <= match_count + 32'h0000_0001;
         end
      end
   end

endmodule : acl_l4_field_matcher

/* File: dv/acl_l4_field_matcher_chk.sv */
`timescale 1ns/10ps
// port assertions for the layer-4 field matcher
module acl_l4_field_matcher_chk (
   input wire logic        i_mclk,
   input wire logic        i_reset_n,
   input wire logic        i_axi_bready,
   input wire logic        i_axi_arvalid,
   input wire logic        i_axi_rready,
   input wire logic        i_frm_valid,
   input wire logic        o_axi_awready,
   input wire logic        o_axi_wready,
   input wire logic        o_axi_bvalid,
   input wire logic [1:0]  o_axi_bresp,
   input wire logic        o_axi_arready,
   input wire logic        o_axi_rvalid,
   input wire logic [31:0] o_axi_rdata,
   input wire logic        o_match_valid,
   input wire logic        o_match
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   chk_match_follows:
   assert property (i_frm_valid |=> o_match_valid)
      else $error("no result after frame");
   chk_match_alone:
   assert property (!i_frm_valid |=> !o_match_valid)
      else $error("result without frame");
   chk_match_qual:
   assert property (!o_match_valid |-> !o_match)
      else $error("match outside result cycle");
   chk_b_hold:
   assert property (o_axi_bvalid && !i_axi_bready |=>
                    o_axi_bvalid && $stable(o_axi_bresp))
      else $error("write response dropped");
   chk_r_hold:
   assert property (o_axi_rvalid && !i_axi_rready |=>
                    o_axi_rvalid && $stable(o_axi_rdata))
      else $error("read response dropped");
   chk_ar_block:
   assert property (o_axi_rvalid |-> !o_axi_arready)
      else $error("read taken while busy");
   chk_aw_block:
   assert property (o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
      else $error("write taken while busy");
   chk_rd_answer:
   assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
      else $error("read not answered");
   chk_b_release:
   assert property (o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid)
      else $error("write response repeated");
   cover property (o_match_valid && o_match);
   cover property (o_match_valid && !o_match);
   cover property (o_axi_bvalid && o_axi_bresp == 2'h2);
endmodule : acl_l4_field_matcher_chk

bind acl_l4_field_matcher acl_l4_field_matcher_chk i_chk (
   .i_mclk, .i_reset_n, .i_axi_bready, .i_axi_arvalid, .i_axi_rready,
   .i_frm_valid, .o_axi_awready, .o_axi_wready, .o_axi_bvalid,
   .o_axi_bresp, .o_axi_arready, .o_axi_rvalid, .o_axi_rdata,
   .o_match_valid, .o_match
);

/* File: dv/rx_header_source.sv */
`timescale 1ns/10ps
// receive pipeline model supplying parsed frame headers
module rx_header_source (
   input  wire logic   i_mclk,
   output logic        o_frm_valid,
   output logic [7:0]  o_frm_ip_proto,
   output logic [7:0]  o_frm_icmp_type,
   output logic [7:0]  o_frm_icmp_code,
   output logic [15:0] o_frm_src_port,
   output logic [15:0] o_frm_dst_port,
   output logic [5:0]  o_frm_tcp_flags
);
   initial begin
      o_frm_valid = 1'b0;
      {o_frm_ip_proto, o_frm_icmp_type, o_frm_icmp_code, o_frm_src_port,
       o_frm_dst_port, o_frm_tcp_flags} = '0;
   end
   // one-cycle header; fields scrambled once released
   task automatic send(input logic [61:0] h);
      @(posedge i_mclk);
      o_frm_valid <= 1'b1;
      {o_frm_ip_proto, o_frm_icmp_type, o_frm_icmp_code, o_frm_src_port,
       o_frm_dst_port, o_frm_tcp_flags} <= h;
      @(posedge i_mclk);
      o_frm_valid <= 1'b0;
      {o_frm_ip_proto, o_frm_icmp_type, o_frm_icmp_code, o_frm_src_port,
       o_frm_dst_port, o_frm_tcp_flags} <= ~h;
   endtask : send
endmodule : rx_header_source

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
// self-checking bench for the layer-4 field matcher
module tb_top;
   logic        i_mclk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        fv, match_valid, match;
   logic [7:0]  ipp, ity, icd;
   logic [15:0] sp, dp;
   logic [5:0]  fl;
   int          failures = 0;
   int          comparisons = 0;

   initial {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
   initial {arvalid, rready} = '0;
   always #25 i_mclk = ~i_mclk;

   rx_header_source i_src (.i_mclk(i_mclk), .o_frm_valid(fv),
      .o_frm_ip_proto(ipp), .o_frm_icmp_type(ity), .o_frm_icmp_code(icd),
      .o_frm_src_port(sp), .o_frm_dst_port(dp), .o_frm_tcp_flags(fl));

   acl_l4_field_matcher i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_axi_awaddr(awaddr), .i_axi_awprot(3'h0), .i_axi_awvalid(awvalid),
      .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf),
      .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
      .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
      .i_axi_arprot(3'h0), .i_axi_arvalid(arvalid),
      .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
      .o_axi_rvalid(rvalid), .i_axi_rready(rready), .i_frm_valid(fv),
      .i_frm_ip_proto(ipp), .i_frm_icmp_type(ity), .i_frm_icmp_code(icd),
      .i_frm_src_port(sp), .i_frm_dst_port(dp), .i_frm_tcp_flags(fl),
      .o_match_valid(match_valid), .o_match(match));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = 2'h0);
      @(posedge i_mclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      do begin
         @(posedge i_mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er = 2'h0);
      @(posedge i_mclk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do begin
         @(posedge i_mclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rd

   task automatic frm(input logic [7:0] p, input logic [15:0] s, d,
                      input logic [5:0] f, input logic e,
                      input logic [7:0] t = 8'h00, c = 8'h00);
      i_src.send({p, t, c, s, d, f});
      #1;
      chk({31'h0, match_valid}, 32'h0000_0001);
      chk({31'h0, match}, {31'h0, e});
   endtask : frm

   task automatic tf(input logic [5:0] f, input logic e);
      frm(8'h06, 16'h0000, 16'h0000, f, e);
   endtask : tf

   task automatic t_reset();
      rd(l4_match_pkg::OFS_CTRL, 32'h0000_0000);
      rd(l4_match_pkg::OFS_SRC_PORT, 32'hffff_0000);
      rd(l4_match_pkg::OFS_TCP_FLAGS, 32'h0000_0aaa);
      rd(8'h30, 32'h0000_0000, 2'h2);
      wr(8'h30, 32'h1234_5678, 2'h2);
      tf(6'h00, 1'b0);
      wr(l4_match_pkg::OFS_CTRL, 32'h0000_0001);
      tf(6'h3f, 1'b1);
   endtask : t_reset

   task automatic t_icmp();
      wr(l4_match_pkg::OFS_CTRL, 32'h0000_0003);
      frm(8'h01, 16'h0000, 16'h0000, 6'h00, 1'b1, 8'h12, 8'h34);
      frm(8'h11, 16'h0000, 16'h0000, 6'h00, 1'b0);
      wr(l4_match_pkg::OFS_ICMP, 32'h0000_ff03);
      frm(8'h3a, 16'h0000, 16'h0000, 6'h00, 1'b1, 8'hff, 8'h00);
      frm(8'h01, 16'h0000, 16'h0000, 6'h00, 1'b0, 8'hfe, 8'h00);
      frm(8'h01, 16'h0000, 16'h0000, 6'h00, 1'b0, 8'hff, 8'h01);
   endtask : t_icmp

   task automatic t_ports();
      logic [15:0] v [4] = '{16'h0063, 16'h0064, 16'h00c8, 16'h00c9};
      wr(l4_match_pkg::OFS_CTRL, 32'h0000_0005);
      wr(l4_match_pkg::OFS_SRC_SEL, 32'h0000_0002);
      wr(l4_match_pkg::OFS_SRC_PORT, 32'h00c8_0064);
      wr(l4_match_pkg::OFS_DST_SEL, 32'h0000_0001);
      wr(l4_match_pkg::OFS_DST_PORT, 32'h0000_ffff);
      for (int i = 0; i < 4; i++) begin
         frm(8'h11, v[i], 16'hffff, 6'h00, i == 1 || i == 2);
      end
      frm(8'h11, 16'h0064, 16'hfffe, 6'h00, 1'b0);
      frm(8'h06, 16'h0064, 16'hffff, 6'h00, 1'b0);
      wr(l4_match_pkg::OFS_DST_SEL, 32'h0000_0002);
      wr(l4_match_pkg::OFS_DST_PORT, 32'h000a_0000);
      frm(8'h11, 16'h0064, 16'h0000, 6'h00, 1'b1);
      frm(8'h11, 16'h0064, 16'h000b, 6'h00, 1'b0);
      wr(l4_match_pkg::OFS_SRC_SEL, 32'h0000_0001);
      wr(l4_match_pkg::OFS_SRC_PORT, 32'h0000_0000);
      frm(8'h11, 16'h0000, 16'h000a, 6'h00, 1'b1);
      frm(8'h11, 16'h0001, 16'h000a, 6'h00, 1'b0);
      wr(l4_match_pkg::OFS_SRC_SEL, 32'h0000_0000);
      wr(l4_match_pkg::OFS_DST_SEL, 32'h0000_0000);
      frm(8'h11, 16'h1234, 16'h4321, 6'h00, 1'b1);
   endtask : t_ports

   task automatic t_flags();
      logic [11:0] m;
      logic [5:0]  b;
      wr(l4_match_pkg::OFS_CTRL, 32'h0000_0007);
      for (int i = 0; i < 6; i++) begin
         b = 6'h01 << i;
         m = 12'h0aaa & ~(12'h003 << (2 * i));
         wr(l4_match_pkg::OFS_TCP_FLAGS, {20'h0_0000, m});
         tf(6'h3f, 1'b0);
         tf(~b, 1'b1);
         m = m | (12'h001 << (2 * i));
         wr(l4_match_pkg::OFS_TCP_FLAGS, {20'h0_0000, m});
         tf(b, 1'b1);
         tf(~b, 1'b0);
      end
      wr(l4_match_pkg::OFS_TCP_FLAGS, 32'h0000_0000);
      wr(l4_match_pkg::OFS_SRC_SEL, 32'h0000_0001);
      wr(l4_match_pkg::OFS_SRC_PORT, 32'h0000_0050);
      frm(8'h06, 16'h0050, 16'h0000, 6'h00, 1'b1);
      frm(8'h06, 16'h0051, 16'h0000, 6'h00, 1'b0);
      frm(8'h06, 16'h0050, 16'h0000, 6'h02, 1'b0);
      wr(l4_match_pkg::OFS_CTRL, 32'h0000_0005);
      frm(8'h11, 16'h0050, 16'h0000, 6'h3f, 1'b1);
      rd(l4_match_pkg::OFS_STATUS, 32'h0000_0003);
      rd(l4_match_pkg::OFS_FRAME_CNT, 32'h0000_002e);
      rd(l4_match_pkg::OFS_MATCH_CNT, 32'h0000_0016);
      wr(l4_match_pkg::OFS_MATCH_CNT, 32'h0000_0000);
      rd(l4_match_pkg::OFS_MATCH_CNT, 32'h0000_0000);
   endtask : t_flags

   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (16) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      t_reset();
      t_icmp();
      t_ports();
      t_flags();
      tally_and_finish();
   end

   initial begin
      #1_000_000;
      failures++;
      tally_and_finish();
   end
endmodule : tb_top
